// ==== verilog/int_arith_pkg.sv ====
/*
  Shared constants and carrier types for the saturating integer arithmetic blocks.
  Assumes a single clock domain; operands arrive as 16-bit two's complement words.
*/
package int_arith_pkg;

  localparam int DATA_W = 16;
  localparam int WIDE_W = 32;

  // Signed result range of one program word
  localparam logic signed [WIDE_W-1:0] RANGE_MAX = 32'h0000_7fff;
  localparam logic signed [WIDE_W-1:0] RANGE_MIN = 32'hffff_8000;

  // Values that stand in for an operand that has no source; ZERO_WORD is the zero-divisor test value
  localparam logic signed [DATA_W-1:0] SUM_OPEN_VALUE = 16'h0000;
  localparam logic signed [DATA_W-1:0] PQ_OPEN_VALUE = 16'h0001;
  localparam logic signed [DATA_W-1:0] ZERO_WORD = 16'h0000;

  // Output state after reset
  localparam logic signed [DATA_W-1:0] RESULT_RESET = 16'h0000;

  // One operand pin of a function block: a value and whether anything feeds it
  typedef struct packed {
    logic connected;
    logic signed [DATA_W-1:0] value;
  } operand_t;

  // Upstream fault pin of a function block
  typedef struct packed {
    logic connected;
    logic active;
  } fault_t;

  // Result pair that a block hands downstream; both fields update together
  typedef struct packed {
    logic saturated;
    logic signed [DATA_W-1:0] value;
  } result_t;

endpackage

// ==== verilog/int_arith_blocks.sv ====
/*
  Sum block (a + b - c) and product/quotient block (a * b / c) of the relay program,
  each with a saturation flag and an upstream fault input.
  Assumes scanTick pulses once per program execution cycle, synchronous to clock;
  operand and fault inputs are stable in the cycle where scanTick is high.
*/
`timescale 1ns/100ps

module int_arith_blocks
  import int_arith_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scanTick,
  input wire operand_t sumIn1,
  input wire operand_t sumIn2,
  input wire operand_t sumIn3,
  input wire fault_t sumFault,
  input wire operand_t pqIn1,
  input wire operand_t pqIn2,
  input wire operand_t pqIn3,
  input wire fault_t pqFault,
  output result_t sumOut_q,
  output result_t pqOut_q,
  output logic evalDone_q
);

  // Clamp a wide value into the word range; the flag reports the clamp separately
  function automatic logic signed [DATA_W-1:0] clampWord(input logic signed [WIDE_W-1:0] v);
    logic signed [DATA_W-1:0] r;
    r = v[DATA_W-1:0];
    if (v > RANGE_MAX) begin
      r = RANGE_MAX[DATA_W-1:0];
    end else if (v < RANGE_MIN) begin
      r = RANGE_MIN[DATA_W-1:0];
    end
    return r;
  endfunction

  logic signed [DATA_W-1:0] sumA, sumB, sumC;
  logic signed [DATA_W-1:0] pqA, pqB, pqC;
  logic signed [WIDE_W-1:0] sumWide, prodWide, quotWide, safeDiv;
  logic sumFaultOn, pqFaultOn, sumOver, pqOver, divZero;
  result_t sumOut_d, pqOut_d;

  always_comb begin
    sumA = sumIn1.connected ? sumIn1.value : SUM_OPEN_VALUE;
    sumB = sumIn2.connected ? sumIn2.value : SUM_OPEN_VALUE;
    sumC = sumIn3.connected ? sumIn3.value : SUM_OPEN_VALUE;
    pqA = pqIn1.connected ? pqIn1.value : PQ_OPEN_VALUE;
    pqB = pqIn2.connected ? pqIn2.value : PQ_OPEN_VALUE;
    pqC = pqIn3.connected ? pqIn3.value : PQ_OPEN_VALUE;
    // A loose fault pin reads as inactive; a wired one carries the upstream flag
    sumFaultOn = sumFault.connected & sumFault.active;
    pqFaultOn = pqFault.connected & pqFault.active;
  end

  // Wide arithmetic so the range check sees the true result
  always_comb begin
    sumWide = WIDE_W'(sumA) + WIDE_W'(sumB) - WIDE_W'(sumC);
    sumOver = (sumWide > RANGE_MAX) || (sumWide < RANGE_MIN);
  end

  always_comb begin
    prodWide = WIDE_W'(pqA) * WIDE_W'(pqB);
    divZero = (pqC == ZERO_WORD);
    // Substitute a harmless divisor so the divider never sees zero
    safeDiv = divZero ? WIDE_W'(PQ_OPEN_VALUE) : WIDE_W'(pqC);
    quotWide = prodWide / safeDiv;
    pqOver = (quotWide > RANGE_MAX) || (quotWide < RANGE_MIN);
  end

  // Faulted or zero-divisor evaluations keep the previous value
  always_comb begin
    sumOut_d = sumOut_q;
    if (sumFaultOn) begin
      sumOut_d.saturated = 1'b1;
    end else begin
      sumOut_d.value = clampWord(sumWide);
      sumOut_d.saturated = sumOver;
    end
  end

  always_comb begin
    pqOut_d = pqOut_q;
    if (pqFaultOn) begin
      pqOut_d.saturated = 1'b1;
    end else if (divZero) begin
      pqOut_d.saturated = 1'b1;
    end else begin
      pqOut_d.value = clampWord(quotWide);
      pqOut_d.saturated = pqOver;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sumOut_q <= '{saturated: 1'b0, value: RESULT_RESET};
    end else if (scanTick) begin
      sumOut_q <= sumOut_d;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pqOut_q <= '{saturated: 1'b0, value: RESULT_RESET};
    end else if (scanTick) begin
      pqOut_q <= pqOut_d;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      evalDone_q <= 1'b0;
    end else begin
      evalDone_q <= scanTick;
    end
  end

  a_sum_fault_flag: assert property (
    @(posedge clock) disable iff (sys_rst)
    scanTick && sumFault.connected && sumFault.active |=> sumOut_q.saturated
    && $stable(sumOut_q.value))
    else $error("sum block missed an upstream fault");

  a_pq_fault_flag: assert property (
    @(posedge clock) disable iff (sys_rst)
    scanTick && pqFault.connected && pqFault.active |=> pqOut_q.saturated
    && $stable(pqOut_q.value))
    else $error("quotient block missed an upstream fault");

  a_open_fault_ignored: assert property (
    @(posedge clock) disable iff (sys_rst)
    scanTick && !sumFault.connected && sumFault.active && !sumIn1.connected
    && !sumIn2.connected && !sumIn3.connected |=> !sumOut_q.saturated
    && sumOut_q.value == ZERO_WORD)
    else $error("open fault pin or open operands misread on sum block");

  a_sum_value_check: assert property (
    @(posedge clock) disable iff (sys_rst)
    scanTick && !sumFaultOn && !sumOver |=> !sumOut_q.saturated
    && (sumOut_q.value == $past(sumA) + $past(sumB) - $past(sumC)))
    else $error("sum result wrong");

  a_sum_range_flag: assert property (
    @(posedge clock) disable iff (sys_rst)
    scanTick && !sumFaultOn && sumOver |=> sumOut_q.saturated
    && (sumOut_q.value == RANGE_MAX[DATA_W-1:0] || sumOut_q.value == RANGE_MIN[DATA_W-1:0]))
    else $error("sum overflow not flagged");

  a_pq_zero_div: assert property (
    @(posedge clock) disable iff (sys_rst)
    scanTick && pqIn3.connected && pqIn3.value == ZERO_WORD |=> pqOut_q.saturated)
    else $error("zero divisor not flagged");

  a_pq_open_ones: assert property (
    @(posedge clock) disable iff (sys_rst)
    scanTick && !pqFaultOn && !pqIn1.connected && !pqIn2.connected && !pqIn3.connected
    |=> pqOut_q.value == PQ_OPEN_VALUE && !pqOut_q.saturated)
    else $error("open quotient operands not read as one");

  a_pq_trunc_zero: assert property (
    @(posedge clock) disable iff (sys_rst)
    scanTick && !pqFaultOn && !divZero && !pqOver |=> !pqOut_q.saturated
    && (WIDE_W'(pqOut_q.value) * $past(safeDiv) + ($past(prodWide) % $past(safeDiv))
    == $past(prodWide)))
    else $error("quotient not truncated toward zero");

  a_hold_between_scans: assert property (
    @(posedge clock) disable iff (sys_rst)
    !scanTick |=> $stable(sumOut_q) && $stable(pqOut_q) && !evalDone_q)
    else $error("outputs changed outside a program cycle");

  a_eval_done_pulse: assert property (
    @(posedge clock) disable iff (sys_rst)
    scanTick |=> evalDone_q)
    else $error("completion pulse missing after a program cycle");

  // A zero divisor must not disturb the last good quotient
  a_pq_zero_hold: assert property (
    @(posedge clock) disable iff (sys_rst)
    scanTick && !pqFaultOn && divZero |=> pqOut_q.saturated
    && $stable(pqOut_q.value))
    else $error("zero divisor changed the quotient value");

  a_pq_range_flag: assert property (
    @(posedge clock) disable iff (sys_rst)
    scanTick && !pqFaultOn && !divZero && pqOver |=> pqOut_q.saturated
    && (pqOut_q.value == RANGE_MAX[DATA_W-1:0] || pqOut_q.value == RANGE_MIN[DATA_W-1:0]))
    else $error("quotient overflow not flagged");

  a_sum_open_fault: assert property (
    @(posedge clock) disable iff (sys_rst)
    scanTick && !sumFault.connected && !sumOver |=> !sumOut_q.saturated)
    else $error("open fault pin raised the sum flag");

  a_pq_open_fault: assert property (
    @(posedge clock) disable iff (sys_rst)
    scanTick && !pqFault.connected && !divZero && !pqOver |=> !pqOut_q.saturated)
    else $error("open fault pin raised the quotient flag");

  // Flag of one evaluation must land on the next edge and match that evaluation's range check
  a_sum_flag_follows: assert property (
    @(posedge clock) disable iff (sys_rst)
    scanTick && !sumFaultOn |=> sumOut_q.saturated == $past(sumOver))
    else $error("sum flag does not match the evaluated range");

  c_sum_overflow: cover property (@(posedge clock) disable iff (sys_rst)
    scanTick && !sumFaultOn && sumOver);
  c_pq_div_zero: cover property (@(posedge clock) disable iff (sys_rst)
    scanTick && !pqFaultOn && divZero);
  c_fault_chain: cover property (@(posedge clock) disable iff (sys_rst)
    scanTick && pqFaultOn && sumOut_q.saturated);
  c_pq_negative: cover property (@(posedge clock) disable iff (sys_rst)
    scanTick && !pqFaultOn && !divZero && quotWide < 0);

endmodule

// ==== dv/chain_link.sv ====
/*
  Link from one function block's result to the next block's upstream fault pin.
  Assumes the feeding block's result is registered in the same clock domain.
*/
`timescale 1ns/100ps
module chain_link
  import int_arith_pkg::*;
(
  input wire result_t src,
  output fault_t faultOut
);
  // A wired link is always connected, so a saturated source always forces the fault
  assign faultOut = {1'h1, src.saturated};
endmodule

// ==== dv/int_arith_blocks_tb.sv ====
/*
  Self-checking bench for the sum and product/quotient blocks.
  Assumes results settle one scan strobe after the operands are presented.
*/
`timescale 1ns/100ps
module int_arith_blocks_tb
  import int_arith_pkg::*;
;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic scanTick = 1'h0;
  logic chainOn = 1'h0;
  logic evalDone;
  operand_t a1 = '0, a2 = '0, a3 = '0, p1 = '0, p2 = '0, p3 = '0;
  fault_t sumFault = '0, tbFault = '0, linkFault, pqFault;
  result_t sumOut, pqOut;
  int num_errors = 0, total_checks = 0, cycles = 0;
  // Open pin carries a junk value that must be ignored
  localparam operand_t OPEN = 17'h0_5a5a;
  always #25 clock = ~clock;
  assign pqFault = chainOn ? linkFault : tbFault;
  int_arith_blocks dut(.clock(clock), .sys_rst(sys_rst), .scanTick(scanTick), .sumIn1(a1),
    .sumIn2(a2), .sumIn3(a3), .sumFault(sumFault), .pqIn1(p1), .pqIn2(p2), .pqIn3(p3),
    .pqFault(pqFault), .sumOut_q(sumOut), .pqOut_q(pqOut), .evalDone_q(evalDone));
  chain_link link(.src(sumOut), .faultOut(linkFault));
  function automatic operand_t op(logic [15:0] v);
    return {1'h1, v};
  endfunction
  task automatic close_out();
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(result_t got, result_t exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic strobe();
    scanTick <= 1'h1;
    @(posedge clock);
    scanTick <= 1'h0;
    #1;
  endtask
  task automatic runSum(operand_t x, operand_t y, operand_t z, fault_t f);
    @(posedge clock);
    {a1, a2, a3, sumFault} <= {x, y, z, f};
    strobe();
  endtask
  task automatic runPq(operand_t x, operand_t y, operand_t z, fault_t f);
    @(posedge clock);
    {p1, p2, p3, tbFault} <= {x, y, z, f};
    strobe();
  endtask
  task automatic sum_cases();
    runSum(op(16'h0064), op(16'h00c8), op(16'h0032), 2'h0);
    chk(sumOut, {1'h0, 16'h00fa});
    chk({evalDone, 16'h0000}, {1'h1, 16'h0000});
    runSum(op(16'h0007), op(16'h0005), OPEN, 2'h1);
    chk(sumOut, {1'h0, 16'h000c});
    runSum(op(16'h7fff), op(16'h0001), OPEN, 2'h0);
    chk(sumOut, {1'h1, 16'h7fff});
    runSum(op(16'h8000), OPEN, op(16'h0001), 2'h0);
    chk(sumOut, {1'h1, 16'h8000});
    runSum(op(16'h0001), op(16'h0001), op(16'h0001), 2'h3);
    chk(sumOut, {1'h1, 16'h8000});
    runSum(OPEN, OPEN, OPEN, 2'h1);
    chk(sumOut, {1'h0, 16'h0000});
  endtask
  task automatic pq_cases();
    runPq(op(16'h0007), op(16'hfff7), op(16'h0002), 2'h0);
    chk(pqOut, {1'h0, 16'hffe1});
    runPq(op(16'h012c), op(16'h012c), op(16'h0001), 2'h0);
    chk(pqOut, {1'h1, 16'h7fff});
    runPq(op(16'h012c), op(16'h012c), op(16'h0003), 2'h0);
    chk(pqOut, {1'h0, 16'h7530});
    runPq(OPEN, op(16'h0014), op(16'h0003), 2'h0);
    chk(pqOut, {1'h0, 16'h0006});
    runPq(op(16'h0005), op(16'h0005), op(16'h0000), 2'h0);
    chk(pqOut, {1'h1, 16'h0006});
    runPq(op(16'h0002), op(16'h0002), op(16'h0001), 2'h3);
    chk(pqOut, {1'h1, 16'h0006});
    runPq(OPEN, OPEN, OPEN, 2'h0);
    chk(pqOut, {1'h0, 16'h0001});
    runPq(op(16'h0002), op(16'h0002), op(16'h0001), 2'h1);
    chk(pqOut, {1'h0, 16'h0004});
  endtask
  task automatic chain_case();
    @(posedge clock);
    chainOn <= 1'h1;
    runSum(op(16'h0001), op(16'h0001), OPEN, 2'h0);
    runSum(op(16'h7fff), op(16'h7fff), OPEN, 2'h0);
    runPq(op(16'h0003), op(16'h0003), op(16'h0001), 2'h0);
    chk(pqOut, {1'h1, 16'h0004});
    runSum(op(16'h0001), op(16'h0001), OPEN, 2'h0);
    runPq(op(16'h0003), op(16'h0003), op(16'h0001), 2'h0);
    chk(pqOut, {1'h0, 16'h0009});
  endtask
  // Mid-run reset must clear both results and the pulse, then evaluation resumes
  task automatic reset_case();
    @(posedge clock);
    sys_rst <= 1'h1;
    @(posedge clock);
    sys_rst <= 1'h0;
    #1;
    chk(sumOut, {1'h0, RESULT_RESET});
    chk(pqOut, {1'h0, RESULT_RESET});
    chk({evalDone, 16'h0000}, {1'h0, 16'h0000});
    runPq(op(16'h0002), op(16'h0003), OPEN, 2'h0);
    chk(pqOut, {1'h0, 16'h0006});
  endtask
  // Whole run needs well under 200 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'h0;
    #1;
    chk(sumOut, {1'h0, RESULT_RESET});
    chk(pqOut, {1'h0, RESULT_RESET});
    sum_cases();
    pq_cases();
    chain_case();
    reset_case();
    close_out();
  end
endmodule
